// File: verilog/emt_top.sv
// external data memory routing, on-chip xram and off-chip strobe timing
// assumes cpu requests and avalon bus on clk_sys; ad_i comes from pins
//
// How it works
// - mode 00: all moves hit on-chip xram
// - internal-only mode aliases addresses modulo 4 kB
// - 8-bit internal: page high, r0/low
// - 16-bit internal: dptr forms whole address
// - mode 01: below xram size on-chip, else off
// - mode 01 8-bit off-chip: high byte undriven
// - mode 01 16-bit off-chip drives all sixteen
// - mode 10 8-bit off-chip: page on high byte
// - mode 11: everything off-chip, xram hidden
// - mode 11 8-bit: page ignored, high undriven
// - mode 11 16-bit: dptr on all lines
// - setup, hold, strobe, latch width programmable
// - access is programmed cycles plus four
// - multiplexed adds latch phases, minimum seven
// - timing register resets to all ones
// - latch high and low each field plus one
// - low address on bus while latch high
`timescale 1ns/100ps
module emt_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [emt_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cpu_valid,
   input emt_pkg::emt_req_s cpu_req,
   output logic cpu_ready,
   output logic cpu_done,
   output logic [7:0] cpu_rdata,
   output logic [7:0] addr_hi_o,
   output logic addr_hi_oe,
   output logic [7:0] addr_lo_o,
   output logic addr_lo_oe,
   input wire logic [7:0] ad_i,
   output logic [7:0] ad_o,
   output logic ad_oe,
   output logic latch_strobe,
   output logic rd_n,
   output logic wr_n
);

   // register file
   logic [7:0] ext_mem_config_reg;
   logic [7:0] xram_page_reg;
   logic [7:0] ext_mem_timing_reg;
   logic [7:0] next_cfg;
   logic [7:0] next_page;
   logic [7:0] next_timing;
   logic ack;
   logic next_ack;
   logic [31:0] next_readdata;
   logic [7:0] reg_idx;
   logic wr_low;
   logic [1:0] mode;
   emt_pkg::emt_state_e state;
   emt_pkg::emt_state_e nst;

   assign reg_idx = avs_address[emt_pkg::ADDR_W-1:2];
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_low = avs_write & ack & avs_byteenable[0];
   assign mode = ext_mem_config_reg[emt_pkg::MODE_LSB +: 2];

   always_comb begin
      next_ack = (avs_read | avs_write) & ~ack;
      next_cfg = ext_mem_config_reg;
      next_page = xram_page_reg;
      next_timing = ext_mem_timing_reg;
      next_readdata = avs_readdata;
      if (wr_low) begin
         case (reg_idx)
            emt_pkg::IDX_CFG: next_cfg = avs_writedata[7:0];
            emt_pkg::IDX_PAGE: next_page = avs_writedata[7:0];
            emt_pkg::IDX_TIMING: next_timing = avs_writedata[7:0];
            default: next_cfg = ext_mem_config_reg;
         endcase
      end
      if (avs_read & ~ack) begin
         case (reg_idx)
            emt_pkg::IDX_CFG: next_readdata = {24'h0, ext_mem_config_reg};
            emt_pkg::IDX_PAGE: next_readdata = {24'h0, xram_page_reg};
            emt_pkg::IDX_TIMING: next_readdata = {24'h0, ext_mem_timing_reg};
            emt_pkg::IDX_STATUS: next_readdata = {23'h0, state, ~cpu_ready};
            default: next_readdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
         avs_readdata <= 32'h0;
         ext_mem_config_reg <= emt_pkg::RST_CFG;
         xram_page_reg <= emt_pkg::RST_PAGE;
         ext_mem_timing_reg <= emt_pkg::RST_TIMING;
      end else begin
         ack <= next_ack;
         avs_readdata <= next_readdata;
         ext_mem_config_reg <= next_cfg;
         xram_page_reg <= next_page;
         ext_mem_timing_reg <= next_timing;
      end
   end

   // routing of a new request
   logic take;
   logic [15:0] eff;
   logic onchip;
   logic start;
   logic [emt_pkg::XRAM_AW-1:0] int_idx;
   logic int_done;
   logic seq_done;
   logic strobe_last;

   assign take = cpu_valid & cpu_ready;

   always_comb begin
      if (cpu_req.wide) begin
         eff = cpu_req.dptr;
      end else begin
         eff = {xram_page_reg, cpu_req.rx};
      end
      case (mode)
         emt_pkg::EMT_INT_ONLY: onchip = 1'b1;
         emt_pkg::EMT_SPLIT_NOBANK,
         emt_pkg::EMT_SPLIT_BANK: onchip = eff < emt_pkg::XRAM_SIZE;
         default: onchip = 1'b0;
      endcase
   end

   assign int_idx = eff[emt_pkg::XRAM_AW-1:0];
   assign start = take & ~onchip;

   // on-chip xram
   logic [7:0] xram [0:(1<<emt_pkg::XRAM_AW)-1];
   logic [7:0] int_rdata;

   always_ff @(posedge clk_sys) begin
      if (take & onchip & cpu_req.wr) begin
         xram[int_idx] <= cpu_req.wdata;
      end
      int_rdata <= xram[int_idx];
   end

   // off-chip request latch
   emt_pkg::emt_tmg_s xtmg;
   emt_pkg::emt_tmg_s next_xtmg;
   logic xwr;
   logic xhi_oe;
   logic [7:0] xhi;
   logic [7:0] xlo;
   logic [7:0] xwdata;
   logic [15:0] xfull;
   logic next_xwr;
   logic next_xhi_oe;
   logic [7:0] next_xhi;
   logic [7:0] next_xlo;
   logic [7:0] next_xwdata;
   logic [15:0] next_xfull;

   always_comb begin
      next_xtmg = xtmg;
      next_xwr = xwr;
      next_xhi_oe = xhi_oe;
      next_xhi = xhi;
      next_xlo = xlo;
      next_xwdata = xwdata;
      next_xfull = xfull;
      if (start) begin
         next_xtmg.mux = ~ext_mem_config_reg[emt_pkg::MUX_BIT];
         next_xtmg.ale = ext_mem_config_reg[emt_pkg::ALE_LSB +: 2];
         next_xtmg.setup = ext_mem_timing_reg[emt_pkg::SETUP_LSB +: 2];
         next_xtmg.strobe = ext_mem_timing_reg[emt_pkg::STROBE_LSB +: 4];
         next_xtmg.hold = ext_mem_timing_reg[emt_pkg::HOLD_LSB +: 2];
         next_xwr = cpu_req.wr;
         next_xwdata = cpu_req.wdata;
         next_xfull = eff;
         // 16-bit moves always drive all lines; 8-bit only with bank select
         next_xhi_oe = cpu_req.wide | (mode == emt_pkg::EMT_SPLIT_BANK);
         next_xhi = cpu_req.wide ? cpu_req.dptr[15:8] : xram_page_reg;
         next_xlo = cpu_req.wide ? cpu_req.dptr[7:0] : cpu_req.rx;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xtmg <= '0;
         xwr <= 1'b0;
         xhi_oe <= 1'b0;
         xhi <= 8'h00;
         xlo <= 8'h00;
         xwdata <= 8'h00;
         xfull <= 16'h0000;
      end else begin
         xtmg <= next_xtmg;
         xwr <= next_xwr;
         xhi_oe <= next_xhi_oe;
         xhi <= next_xhi;
         xlo <= next_xlo;
         xwdata <= next_xwdata;
         xfull <= next_xfull;
      end
   end

   emt_seq u_seq (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(start),
      .tmg(xtmg),
      .state(state),
      .next_state(nst),
      .strobe_last(strobe_last),
      .done(seq_done)
   );

   // pin drive, registered from the sequencer's next phase
   logic act;
   logic dat_ph;
   logic next_addr_hi_oe;
   logic [7:0] next_addr_hi;
   logic next_addr_lo_oe;
   logic [7:0] next_addr_lo;
   logic next_ad_oe;
   logic [7:0] next_ad;
   logic next_latch;
   logic next_rd_n;
   logic next_wr_n;

   always_comb begin
      act = (nst != emt_pkg::EMT_IDLE) && (nst != emt_pkg::EMT_TAIL);
      dat_ph = next_xwr && ((nst == emt_pkg::EMT_SETUP)
         || (nst == emt_pkg::EMT_STROBE) || (nst == emt_pkg::EMT_HOLD)
         || (nst == emt_pkg::EMT_ALE_LO)
         || (nst == emt_pkg::EMT_ADDR && !next_xtmg.mux));
      next_addr_hi_oe = act & next_xhi_oe;
      next_addr_hi = act ? next_xhi : 8'h00;
      next_addr_lo_oe = act & ~next_xtmg.mux;
      next_addr_lo = act ? next_xlo : 8'h00;
      next_latch = next_xtmg.mux && (nst == emt_pkg::EMT_ALE_HI);
      if (next_xtmg.mux && ((nst == emt_pkg::EMT_ADDR)
         || (nst == emt_pkg::EMT_ALE_HI))) begin
         next_ad_oe = 1'b1;
         next_ad = next_xlo;
      end else if (dat_ph) begin
         next_ad_oe = 1'b1;
         next_ad = next_xwdata;
      end else begin
         next_ad_oe = 1'b0;
         next_ad = 8'h00;
      end
      next_rd_n = ~((nst == emt_pkg::EMT_STROBE) & ~next_xwr);
      next_wr_n = ~((nst == emt_pkg::EMT_STROBE) & next_xwr);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         addr_hi_oe <= 1'b0;
         addr_hi_o <= 8'h00;
         addr_lo_oe <= 1'b0;
         addr_lo_o <= 8'h00;
         ad_oe <= 1'b0;
         ad_o <= 8'h00;
         latch_strobe <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end else begin
         addr_hi_oe <= next_addr_hi_oe;
         addr_hi_o <= next_addr_hi;
         addr_lo_oe <= next_addr_lo_oe;
         addr_lo_o <= next_addr_lo;
         ad_oe <= next_ad_oe;
         ad_o <= next_ad;
         latch_strobe <= next_latch;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
      end
   end

   // read data: pin synchroniser, captured two cycles after strobe end
   logic [7:0] ad_s1;
   logic [7:0] ad_s2;
   logic [1:0] cap;
   logic [1:0] next_cap;
   logic int_pend;
   logic [7:0] next_rdata;

   always_comb begin
      next_cap = {cap[0], strobe_last & ~xwr};
      if (cap[1]) begin
         next_rdata = ad_s2;
      end else begin
         next_rdata = cpu_rdata;
      end
      if (int_pend) begin
         next_rdata = int_rdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ad_s1 <= 8'h00;
         ad_s2 <= 8'h00;
         cap <= 2'h0;
         int_done <= 1'b0;
         cpu_rdata <= 8'h00;
      end else begin
         ad_s1 <= ad_i;
         ad_s2 <= ad_s1;
         cap <= next_cap;
         int_done <= take & onchip;
         cpu_rdata <= next_rdata;
      end
   end

   assign int_pend = int_done;
   assign cpu_done = int_done | seq_done;
   assign cpu_ready = (state == emt_pkg::EMT_IDLE) & ~int_done;

   // checks
   logic [5:0] acc_cnt;
   logic [5:0] exp_len;
   logic [4:0] low_cnt;
   logic first_cyc;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_cnt <= 6'h00;
         low_cnt <= 5'h00;
         first_cyc <= 1'b1;
      end else begin
         acc_cnt <= start ? 6'h01 : acc_cnt + 6'h01;
         low_cnt <= (rd_n & wr_n) ? 5'h00 : low_cnt + 5'h01;
         first_cyc <= 1'b0;
      end
   end

   assign exp_len = {4'h0, xtmg.setup} + {2'h0, xtmg.strobe} + 6'h01
      + {4'h0, xtmg.hold} + emt_pkg::FIXED_CYC
      + (xtmg.mux ? ({3'h0, xtmg.ale, 1'b0} + 6'h02) : 6'h00);

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_latch_hi;
      latch_strobe && ad_oe && (ad_o == xlo);
   endsequence

   chk_int_no_ext: assert property (
      take && mode == emt_pkg::EMT_INT_ONLY |=> cpu_done && rd_n && wr_n)
      else $error("internal-only access left the chip");
   chk_alias_idx: assert property (
      take && onchip |-> int_idx == (cpu_req.wide ? cpu_req.dptr[11:0]
         : {xram_page_reg[3:0], cpu_req.rx}))
      else $error("xram index not aliased modulo 4 kB");
   chk_split_route: assert property (
      take && (mode == emt_pkg::EMT_SPLIT_NOBANK) |-> onchip == (eff < 16'h1000))
      else $error("split mode routed wrongly");
   chk_ext_route: assert property (
      take && mode == emt_pkg::EMT_EXT_ONLY |=> state == emt_pkg::EMT_ADDR)
      else $error("external-only access stayed on-chip");
   chk_hi_undriven: assert property (
      !rd_n && !xhi_oe |-> !addr_hi_oe)
      else $error("upper address driven without bank select");
   chk_bank_hi: assert property (
      !(rd_n && wr_n) && xhi_oe |-> addr_hi_oe && addr_hi_o == xfull[15:8])
      else $error("upper address byte wrong");
   chk_access_len: assert property (
      seq_done |-> acc_cnt == exp_len && acc_cnt >= 6'h05)
      else $error("off-chip access length wrong");
   chk_strobe_width: assert property (
      $rose(rd_n & wr_n) |-> low_cnt == {1'b0, xtmg.strobe} + 5'h01)
      else $error("strobe width wrong");
   chk_latch_phase: assert property (
      $rose(latch_strobe) |-> s_latch_hi ##1 (latch_strobe || !ad_oe
         || xwr) ##0 (addr_lo_oe == 1'b0))
      else $error("low address not on bus while latch high");
   chk_timing_reset: assert property (
      first_cyc |-> ext_mem_timing_reg == 8'hff)
      else $error("timing register reset value wrong");

endmodule

// File: verilog/emt_pkg.sv
// constants, types and register map of the external memory mode/timing block
// assumes a single system clock domain; used by emt_top and emt_seq
package emt_pkg;

   // register bus: byte address = register index * 4
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_CFG = 8'ha0;
   localparam logic [7:0] IDX_PAGE = 8'ha1;
   localparam logic [7:0] IDX_STATUS = 8'ha2;
   localparam logic [7:0] IDX_TIMING = 8'haa;

   // reset values
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [7:0] RST_TIMING = 8'hff;

   // timing register fields
   localparam int SETUP_LSB = 6;
   localparam int STROBE_LSB = 2;
   localparam int HOLD_LSB = 0;
   // config register fields
   localparam int MUX_BIT = 4;
   localparam int MODE_LSB = 2;
   localparam int ALE_LSB = 0;

   // on-chip xram
   localparam int XRAM_AW = 12;
   localparam logic [15:0] XRAM_SIZE = 16'h1000;

   // fixed cycles: one address cycle, then three tail cycles
   localparam logic [3:0] TAIL_CYC = 4'h3;
   localparam logic [5:0] FIXED_CYC = 6'h04;

   typedef enum logic [1:0] {
      EMT_INT_ONLY = 2'h0,
      EMT_SPLIT_NOBANK = 2'h1,
      EMT_SPLIT_BANK = 2'h2,
      EMT_EXT_ONLY = 2'h3
   } emt_mode_e;

   typedef enum logic [7:0] {
      EMT_IDLE = 8'h01,
      EMT_ADDR = 8'h02,
      EMT_ALE_HI = 8'h04,
      EMT_ALE_LO = 8'h08,
      EMT_SETUP = 8'h10,
      EMT_STROBE = 8'h20,
      EMT_HOLD = 8'h40,
      EMT_TAIL = 8'h80
   } emt_state_e;

   typedef struct packed {
      logic wr;
      logic wide;
      logic [15:0] dptr;
      logic [7:0] rx;
      logic [7:0] wdata;
   } emt_req_s;

   typedef struct packed {
      logic mux;
      logic [1:0] ale;
      logic [1:0] setup;
      logic [3:0] strobe;
      logic [1:0] hold;
   } emt_tmg_s;

endpackage

// File: verilog/emt_seq.sv
// off-chip access phase sequencer
// assumes tmg is stable from the cycle after start until done
`timescale 1ns/100ps
module emt_seq (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   input emt_pkg::emt_tmg_s tmg,
   output emt_pkg::emt_state_e state,
   output emt_pkg::emt_state_e next_state,
   output logic strobe_last,
   output logic done
);

   logic [3:0] cnt;
   logic [3:0] next_cnt;
   emt_pkg::emt_state_e after_pre;
   logic [3:0] pre_cnt;

   always_comb begin
      // phase that follows address or latch phases
      if (tmg.setup != 2'h0) begin
         after_pre = emt_pkg::EMT_SETUP;
         pre_cnt = {2'h0, tmg.setup} - 4'h1;
      end else begin
         after_pre = emt_pkg::EMT_STROBE;
         pre_cnt = tmg.strobe;
      end
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         emt_pkg::EMT_IDLE: begin
            if (start) begin
               next_state = emt_pkg::EMT_ADDR;
            end
         end
         emt_pkg::EMT_ADDR: begin
            if (tmg.mux) begin
               next_state = emt_pkg::EMT_ALE_HI;
               next_cnt = {2'h0, tmg.ale};
            end else begin
               next_state = after_pre;
               next_cnt = pre_cnt;
            end
         end
         emt_pkg::EMT_ALE_HI: begin
            if (cnt == 4'h0) begin
               next_state = emt_pkg::EMT_ALE_LO;
               next_cnt = {2'h0, tmg.ale};
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         emt_pkg::EMT_ALE_LO: begin
            if (cnt == 4'h0) begin
               next_state = after_pre;
               next_cnt = pre_cnt;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         emt_pkg::EMT_SETUP: begin
            if (cnt == 4'h0) begin
               next_state = emt_pkg::EMT_STROBE;
               next_cnt = tmg.strobe;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         emt_pkg::EMT_STROBE: begin
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else if (tmg.hold != 2'h0) begin
               next_state = emt_pkg::EMT_HOLD;
               next_cnt = {2'h0, tmg.hold} - 4'h1;
            end else begin
               next_state = emt_pkg::EMT_TAIL;
               next_cnt = emt_pkg::TAIL_CYC - 4'h1;
            end
         end
         emt_pkg::EMT_HOLD: begin
            if (cnt == 4'h0) begin
               next_state = emt_pkg::EMT_TAIL;
               next_cnt = emt_pkg::TAIL_CYC - 4'h1;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         emt_pkg::EMT_TAIL: begin
            if (cnt == 4'h0) begin
               next_state = emt_pkg::EMT_IDLE;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         default: begin
            next_state = emt_pkg::EMT_IDLE;
            next_cnt = 4'h0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= emt_pkg::EMT_IDLE;
         cnt <= 4'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign strobe_last = (state == emt_pkg::EMT_STROBE) && (cnt == 4'h0);
   assign done = (state == emt_pkg::EMT_TAIL) && (cnt == 4'h0);

endmodule

// File: sim/emt_xmem_model.sv
// external parallel memory with its address latch, for emt_top's pins
// assumes registered pins on clk_sys; upper lines undriven use port_hi
`timescale 1ns/100ps
module emt_xmem_model (
   input wire logic clk_sys,
   input wire logic mux_mode,
   input wire logic [7:0] port_hi,
   input wire logic [7:0] addr_hi_o,
   input wire logic addr_hi_oe,
   input wire logic [7:0] addr_lo_o,
   input wire logic [7:0] ad_o,
   input wire logic ad_oe,
   input wire logic latch_strobe,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [7:0] ad_i
);
   logic [7:0] mem [0:65535];
   logic [7:0] lat = 8'h00;
   logic [7:0] last = 8'h00;
   logic [15:0] addr;

   // latch loads ad_o on each clock edge while high, holds from the fall
   always @(posedge clk_sys)
      if (latch_strobe && ad_oe)
         lat <= ad_o;

   assign addr = {addr_hi_oe ? addr_hi_o : port_hi,
                  mux_mode ? lat : addr_lo_o};

   always @(posedge clk_sys) begin
      if (!wr_n)
         mem[addr] <= ad_o;
      if (!rd_n)
         last <= ad_i;
   end

   // released bus shows the inverse of the last value
   assign ad_i = !rd_n ? mem[addr] : ~last;
endmodule

// File: sim/testbench.sv
// self-checking bench for emt_top with the external memory model
// assumes emt_pkg and the design files are compiled first
`timescale 1ns/100ps
module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] be = 4'hf;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, tmp;
   logic avs_waitrequest, cpu_ready, cpu_done;
   logic cpu_valid = 1'b0;
   emt_pkg::emt_req_s req = '0;
   logic [7:0] cpu_rdata, ahi, alo, ad_o, ad_i;
   logic ahi_oe, alo_oe, ad_oe, lat_s, rd_n, wr_n;
   logic mux = 1'b1;
   int num_errors = 0;
   int compares = 0;
   int n_strb, n_pre, n_hold, n_lat, n_cyc;
   logic hi_seen;
   logic [7:0] hi_val, lo_val, ad_lat, got;
   logic [7:0] tms [4] = '{8'h00, 8'hff, 8'h96, 8'h4d};

   initial forever #50 clk_sys = ~clk_sys;

   emt_top DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(be),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cpu_valid(cpu_valid),
      .cpu_req(req), .cpu_ready(cpu_ready), .cpu_done(cpu_done),
      .cpu_rdata(cpu_rdata), .addr_hi_o(ahi), .addr_hi_oe(ahi_oe),
      .addr_lo_o(alo), .addr_lo_oe(alo_oe), .ad_i(ad_i), .ad_o(ad_o),
      .ad_oe(ad_oe), .latch_strobe(lat_s), .rd_n(rd_n), .wr_n(wr_n));

   emt_xmem_model XMEM (.clk_sys(clk_sys), .mux_mode(mux),
      .port_hi(8'h30), .addr_hi_o(ahi), .addr_hi_oe(ahi_oe),
      .addr_lo_o(alo), .ad_o(ad_o), .ad_oe(ad_oe), .latch_strobe(lat_s),
      .rd_n(rd_n), .wr_n(wr_n), .ad_i(ad_i));

   // pin activity of the current access
   always @(posedge clk_sys) begin
      if (!rd_n || !wr_n) begin
         n_strb++;
         hi_seen |= ahi_oe;
         hi_val = ahi;
         lo_val = alo;
      end else if (alo_oe && n_strb == 0)
         n_pre++;
      else if (alo_oe)
         n_hold++;
      if (lat_s) begin
         n_lat++;
         ad_lat = ad_o;
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic give_verdict();
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic hang();
      num_errors++;
      give_verdict();
   endtask

   task automatic bus(input logic w, input logic [7:0] idx,
         input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h0, wd};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20)
         hang();
      tmp = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 8'h00);
      chk(tmp, e);
   endtask

   task automatic setcfg(input logic [7:0] v);
      mux = ~v[4];
      wr(emt_pkg::IDX_CFG, v);
   endtask

   task automatic cpu(input logic w, input logic wide, input logic [15:0] dp,
         input logic [7:0] rx, input logic [7:0] wd);
      int n;
      @(negedge clk_sys);
      n_strb = 0;
      n_pre = 0;
      n_hold = 0;
      n_lat = 0;
      hi_seen = 1'b0;
      @(posedge clk_sys);
      cpu_valid <= 1'b1;
      req <= {w, wide, dp, rx, wd};
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (cpu_ready !== 1'b1 && n < 50);
      cpu_valid <= 1'b0;
      n_cyc = 0;
      do begin
         @(posedge clk_sys);
         n_cyc++;
      end while (cpu_done !== 1'b1 && n_cyc < 200);
      if (n >= 50 || n_cyc >= 200)
         hang();
      @(negedge clk_sys);
      got = cpu_rdata;
   endtask

   task automatic offchk(input logic [7:0] tm, input logic [7:0] cf);
      int s, w, h, a;
      s = tm[7:6];
      w = tm[5:2];
      h = tm[1:0];
      a = cf[1:0];
      chk(n_cyc, s + w + h + 5 + (cf[4] ? 0 : 2 * a + 2));
      chk(n_strb, w + 1);
      if (cf[4]) begin
         chk(n_pre, s + 1);
         chk(n_hold, h);
      end else
         chk(n_lat, a + 1);
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rd(emt_pkg::IDX_TIMING, 32'hff);
      rd(emt_pkg::IDX_CFG, 32'h0);
      rd(emt_pkg::IDX_STATUS, 32'h2);
      wr(8'h10, 8'h77);
      rd(8'h10, 32'h0);
      be <= 4'h0;
      wr(emt_pkg::IDX_TIMING, 8'h00);
      be <= 4'hf;
      rd(emt_pkg::IDX_TIMING, 32'hff);
      wr(emt_pkg::IDX_TIMING, 8'h5a);
      rd(emt_pkg::IDX_TIMING, 32'h5a);
      cpu(1'b1, 1'b1, 16'h0123, 8'h00, 8'h3c);
      chk(n_cyc, 1);
      chk(n_strb, 0);
      cpu(1'b0, 1'b1, 16'h2123, 8'h00, 8'h00);
      chk(got, 8'h3c);
      wr(emt_pkg::IDX_PAGE, 8'h51);
      cpu(1'b0, 1'b0, 16'h0000, 8'h23, 8'h00);
      chk(got, 8'h3c);
      setcfg(8'h1c);
      for (int i = 0; i < 4; i++) begin
         wr(emt_pkg::IDX_TIMING, tms[i]);
         cpu(1'b1, 1'b1, 16'h0040 + 16'(i), 8'h00, 8'ha0 + 8'(i));
         offchk(tms[i], 8'h1c);
         chk({hi_val, lo_val}, 16'h0040 + 16'(i));
         cpu(1'b0, 1'b1, 16'h0040 + 16'(i), 8'h00, 8'h00);
         chk(got, 8'ha0 + 8'(i));
      end
      wr(emt_pkg::IDX_TIMING, 8'h00);
      for (logic [7:0] a = 0; a < 4; a++) begin
         setcfg(8'h0c | a);
         cpu(1'b1, 1'b1, {8'h12, a}, 8'h00, 8'hc0 + a);
         offchk(8'h00, 8'h0c | a);
         chk(ad_lat, a);
         cpu(1'b0, 1'b1, {8'h12, a}, 8'h00, 8'h00);
         chk(got, 8'hc0 + a);
      end
      setcfg(8'h14);
      cpu(1'b0, 1'b1, 16'h0fff, 8'h00, 8'h00);
      chk(n_cyc, 1);
      cpu(1'b1, 1'b1, 16'h1000, 8'h00, 8'h99);
      chk({hi_seen, hi_val, lo_val}, {1'b1, 16'h1000});
      wr(emt_pkg::IDX_PAGE, 8'h30);
      cpu(1'b1, 1'b0, 16'h0000, 8'h55, 8'h6e);
      chk({hi_seen, lo_val}, {1'b0, 8'h55});
      setcfg(8'h18);
      wr(emt_pkg::IDX_PAGE, 8'h31);
      cpu(1'b1, 1'b0, 16'h0000, 8'h55, 8'h7d);
      chk({hi_seen, hi_val, lo_val}, {1'b1, 16'h3155});
      wr(emt_pkg::IDX_PAGE, 8'h00);
      cpu(1'b0, 1'b0, 16'h0000, 8'h23, 8'h00);
      chk(n_cyc, 1);
      setcfg(8'h1c);
      cpu(1'b0, 1'b0, 16'h0000, 8'h55, 8'h00);
      chk({hi_seen, got}, {1'b0, 8'h6e});
      cpu(1'b0, 1'b1, 16'h3155, 8'h00, 8'h00);
      chk(got, 8'h7d);
      give_verdict();
   end
endmodule
